// File: hw/pac_top.sv
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module pac_top #(
    parameter int MS_CYC = pac_pkg::MS_CYC,
    parameter int CLOSE_CYC = pac_pkg::SW_CLOSE_CYC,
    parameter int BOUNCE_CYC = pac_pkg::SW_BOUNCE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensor comparators
    input wire pac_pkg::pac_pins_t pins [pac_pkg::NCH],
    // Sequencer hold-off of the interval end
    input wire logic seq_hold,
    // Interrupt
    output logic irq
);

    localparam int NCH = pac_pkg::NCH;

    logic [15:0] count [NCH];
    logic [15:0] snap [NCH];
    logic [31:0] result [NCH];
    logic [31:0] next_result [NCH];
    logic [15:0] next_snap [NCH];

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [31:0] cfg;
    logic [15:0] interval;
    logic locked;
    logic hires;
    logic [2:0] status;
    logic [2:0] enable;
    logic [31:0] next_cfg;
    logic [15:0] next_interval;
    logic next_locked;
    logic next_hires;
    logic [2:0] next_status;
    logic [2:0] next_enable;
    logic [31:0] next_prdata;
    logic resync;
    logic wr_en;
    logic setup;
    logic mapped;
    logic [2:0] events;

    // Interval timer state
    logic [14:0] presc;
    logic [16:0] elapsed;
    logic [16:0] snap_ms;
    logic snap_long;
    logic [14:0] next_presc;
    logic [16:0] next_elapsed;
    logic [16:0] next_snap_ms;
    logic next_snap_long;
    logic boundary;

    // Engine state
    pac_pkg::pac_state_t state;
    pac_pkg::pac_state_t next_state;
    logic [1:0] ch;
    logic [1:0] next_ch;
    logic [31:0] val;
    logic [31:0] next_val;
    logic div_start;
    logic div_done;
    logic [31:0] div_quot;
    pac_pkg::pac_cfg_t ch_cfg;

    ////////////////////////////////////////////////////////////////////////
    // Channels
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            pac_pkg::pac_cfg_t c;
            assign c = cfg[gi*8 +: 8];
            pac_chan #(
                .CLOSE_CYC(CLOSE_CYC),
                .BOUNCE_CYC(BOUNCE_CYC)
            ) u_chan (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .in_type(c.in_type),
                .clear(boundary),
                .pins(pins[gi]),
                .count(count[gi])
            );
            // Snapshot in the clearing cycle
            assign next_snap[gi] = boundary ? count[gi] : snap[gi];
        end
    endgenerate

    pac_div u_div (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(div_start),
        .dividend(32'({16'h0, snap[ch]}) * pac_pkg::HZ_PER_MS),
        .divisor(snap_ms[15:0]),
        .quotient(div_quot),
        .done(div_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interval timer with resync and sequencer hold-off
    always_comb begin
        next_presc = presc + 15'h1;
        next_elapsed = elapsed;
        next_snap_ms = snap_ms;
        next_snap_long = snap_long;
        boundary = (interval != 16'h0) && (elapsed >= {1'b0, interval})
            && !seq_hold && (state == pac_pkg::ST_IDLE);
        if (presc == 15'(MS_CYC - 1)) begin
            next_presc = 15'h0;
            if (elapsed != 17'h1ffff) begin
                next_elapsed = elapsed + 17'h1;
            end
        end
        if (resync) begin
            next_presc = 15'h0;
            next_elapsed = 17'h0;
        end else if (boundary) begin
            next_presc = 15'h0;
            next_elapsed = 17'h0;
            next_snap_ms = elapsed;
            next_snap_long = elapsed > {1'b0, interval};
        end
    end

    // Timer registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            presc <= 15'h0;
            elapsed <= 17'h0;
            snap_ms <= 17'h0;
            snap_long <= 1'b0;
        end else begin
            presc <= next_presc;
            elapsed <= next_elapsed;
            snap_ms <= next_snap_ms;
            snap_long <= next_snap_long;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result engine, one channel per repetition
    assign ch_cfg = cfg[ch*8 +: 8];

    always_comb begin
        next_state = state;
        next_ch = ch;
        next_val = val;
        div_start = 1'b0;
        events = 3'h0;
        events[pac_pkg::EV_BOUNDARY] = boundary;
        events[pac_pkg::EV_LONG] = boundary && (elapsed > {1'b0, interval});
        for (int i = 0; i < NCH; i++) begin
            next_result[i] = result[i];
        end
        case (state)
            pac_pkg::ST_IDLE: begin
                next_ch = 2'h0;
                if (boundary) begin
                    next_state = pac_pkg::ST_PICK;
                end
            end
            pac_pkg::ST_PICK: begin
                next_val = {16'h0, snap[ch]};
                next_state = pac_pkg::ST_STORE;
                if (ch_cfg.mode != pac_pkg::MODE_ALL && snap_long
                    && ch_cfg.mode != 2'h3) begin
                    next_state = pac_pkg::ST_STORE;
                end
                if (ch_cfg.mode == pac_pkg::MODE_FREQ) begin
                    div_start = 1'b1;
                    next_state = pac_pkg::ST_DIV;
                end
            end
            pac_pkg::ST_DIV: begin
                if (div_done) begin
                    next_val = div_quot;
                    next_state = pac_pkg::ST_STORE;
                end
            end
            pac_pkg::ST_STORE: begin
                if ((ch_cfg.mode == pac_pkg::MODE_DISCARD
                     || ch_cfg.mode == pac_pkg::MODE_FREQ) && snap_long) begin
                    next_result[ch] = result[ch];
                end else if (val > pac_pkg::RESULT_MAX) begin
                    next_result[ch] = hires ? pac_pkg::OVR_HIRES
                        : pac_pkg::OVR_LORES;
                    events[pac_pkg::EV_OVR] = 1'b1;
                end else begin
                    next_result[ch] = val;
                end
                next_ch = ch + 2'h1;
                next_state = (ch == 2'(NCH - 1)) ? pac_pkg::ST_IDLE
                    : pac_pkg::ST_PICK;
            end
            default: begin
                next_state = pac_pkg::ST_IDLE;
            end
        endcase
    end

    // Engine registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= pac_pkg::ST_IDLE;
            ch <= 2'h0;
            val <= 32'h0;
            for (int i = 0; i < NCH; i++) begin
                result[i] <= 32'h0;
                snap[i] <= 16'h0;
            end
        end else begin
            state <= next_state;
            ch <= next_ch;
            val <= next_val;
            for (int i = 0; i < NCH; i++) begin
                result[i] <= next_result[i];
                snap[i] <= next_snap[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states, read data latched in setup
    assign pready = 1'b1;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign mapped = (paddr <= pac_pkg::OFS_CFG && paddr[1:0] == 2'h0)
        || (paddr >= pac_pkg::OFS_RESULT0 && paddr < 12'h040
            && paddr[1:0] == 2'h0);
    assign pslverr = psel && penable && !mapped;
    assign resync = wr_en && paddr == pac_pkg::OFS_CTRL
        && pwdata[pac_pkg::CTRL_RESYNC];
    assign irq = |(status & enable);

    always_comb begin
        next_cfg = cfg;
        next_interval = interval;
        next_locked = locked;
        next_hires = hires;
        next_enable = enable;
        next_status = status;
        next_prdata = prdata;
        // Software clear first, events win over it
        if (wr_en && paddr == pac_pkg::OFS_CLEAR) begin
            next_status = status & ~pwdata[2:0];
        end
        next_status = next_status | events;
        if (wr_en) begin
            case (paddr)
                pac_pkg::OFS_CTRL: begin
                    next_hires = pwdata[pac_pkg::CTRL_HIRES];
                    if (pwdata[pac_pkg::CTRL_UNLOCK]) begin
                        next_locked = 1'b0;
                    end
                end
                pac_pkg::OFS_INTERVAL: begin
                    if (!locked) begin
                        next_interval = pwdata[15:0];
                        next_locked = 1'b1;
                    end
                end
                pac_pkg::OFS_ENABLE: next_enable = pwdata[2:0];
                pac_pkg::OFS_CFG: next_cfg = pwdata;
                default: begin
                    next_cfg = cfg;
                end
            endcase
        end
        if (setup) begin
            next_prdata = 32'h0;
            case (paddr)
                pac_pkg::OFS_CTRL: begin
                    next_prdata[pac_pkg::CTRL_HIRES] = hires;
                    next_prdata[pac_pkg::CTRL_LOCKED] = locked;
                    next_prdata[pac_pkg::CTRL_BUSY] =
                        state != pac_pkg::ST_IDLE;
                end
                pac_pkg::OFS_INTERVAL: next_prdata[15:0] = interval;
                pac_pkg::OFS_STATUS: next_prdata[2:0] = status;
                pac_pkg::OFS_ENABLE: next_prdata[2:0] = enable;
                pac_pkg::OFS_CFG: next_prdata = cfg;
                default: begin
                    if (paddr >= pac_pkg::OFS_COUNT0 && mapped) begin
                        next_prdata[15:0] = count[paddr[3:2]];
                    end else if (paddr >= pac_pkg::OFS_RESULT0 && mapped) begin
                        next_prdata = result[paddr[3:2]];
                    end
                end
            endcase
        end
    end

    // Register file
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg <= pac_pkg::CFG_RESET;
            interval <= pac_pkg::INTERVAL_RESET;
            locked <= 1'b0;
            hires <= 1'b0;
            status <= 3'h0;
            enable <= 3'h0;
            prdata <= 32'h0;
        end else begin
            cfg <= next_cfg;
            interval <= next_interval;
            locked <= next_locked;
            hires <= next_hires;
            status <= next_status;
            enable <= next_enable;
            prdata <= next_prdata;
        end
    end

endmodule : pac_top

// File: hw/pac_pkg.sv
package pac_pkg;

    // Geometry
    localparam int NCH = 4;
    localparam int CNT_W = 16;
    localparam int MS_W = 17;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [31:0] RESULT_MAX = 32'h0000_7fff;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_INTERVAL = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_CLEAR = 12'h00c;
    localparam logic [11:0] OFS_ENABLE = 12'h010;
    localparam logic [11:0] OFS_CFG = 12'h014;
    localparam logic [11:0] OFS_RESULT0 = 12'h020;
    localparam logic [11:0] OFS_COUNT0 = 12'h030;

    // Control bit positions
    localparam int CTRL_UNLOCK = 0;
    localparam int CTRL_RESYNC = 1;
    localparam int CTRL_HIRES = 2;
    localparam int CTRL_LOCKED = 3;
    localparam int CTRL_BUSY = 4;

    // Event bit positions
    localparam int EV_W = 3;
    localparam int EV_BOUNDARY = 0;
    localparam int EV_LONG = 1;
    localparam int EV_OVR = 2;

    // Configuration byte: [5:4] mode, [1:0] input type
    localparam int CFG_W = 8;
    localparam logic [1:0] TYPE_FAST = 2'h0;
    localparam logic [1:0] TYPE_AC = 2'h1;
    localparam logic [1:0] TYPE_SWITCH = 2'h2;
    localparam logic [1:0] MODE_ALL = 2'h0;
    localparam logic [1:0] MODE_DISCARD = 2'h1;
    localparam logic [1:0] MODE_FREQ = 2'h2;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [15:0] INTERVAL_RESET = 16'h0000;

    // Overrange result codes
    localparam logic [31:0] OVR_HIRES = 32'hfffe_7961;
    localparam logic [31:0] OVR_LORES = 32'hffff_e4a9;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int FAST_MIN_PULSE_NS = 2000;
    localparam int FAST_MAX_RATE_KHZ = 250;
    localparam int FAST_PULSE_CYC = FAST_MIN_PULSE_NS / CLK_PERIOD_NS;
    localparam int SW_CLOSE_US = 1000;
    localparam int SW_BOUNCE_US = 1400;
    localparam int SW_OPEN_US = 4000;
    localparam int SW_CLOSE_CYC = SW_CLOSE_US * 1000 / CLK_PERIOD_NS;
    localparam int SW_BOUNCE_CYC =
        (SW_BOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
    localparam logic [31:0] HZ_PER_MS = 32'd1000;
    localparam int DIV_STEPS = 32;

    // Comparator levels of one channel
    typedef struct packed {
        logic fast_above;
        logic fast_below;
        logic ac_pos;
        logic sw_closed;
    } pac_pins_t;

    // Per-channel configuration
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic [1:0] mode;
        logic [1:0] rsv_lo;
        logic [1:0] in_type;
    } pac_cfg_t;

    // Engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PICK = 4'b0010,
        ST_DIV = 4'b0100,
        ST_STORE = 4'b1000
    } pac_state_t;

endpackage : pac_pkg

// File: hw/pac_chan.sv
`timescale 1ns/1ps
module pac_chan #(
    parameter int CLOSE_CYC = pac_pkg::SW_CLOSE_CYC,
    parameter int BOUNCE_CYC = pac_pkg::SW_BOUNCE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Configuration and interval clear
    input wire logic [1:0] in_type,
    input wire logic clear,
    // Comparator levels
    input wire pac_pkg::pac_pins_t pins,
    // Running count
    output logic [15:0] count
);

    logic armed;
    logic ac_prev;
    logic sw_state;
    logic [14:0] sw_cnt;
    logic next_armed;
    logic next_ac_prev;
    logic next_sw_state;
    logic [14:0] next_sw_cnt;
    logic [15:0] next_count;
    logic edge_ev;

    ////////////////////////////////////////////////////////////////////////
    // Edge detection per input type
    always_comb begin
        next_armed = armed;
        next_ac_prev = pins.ac_pos;
        next_sw_state = sw_state;
        next_sw_cnt = 15'h0;
        edge_ev = 1'b0;
        // Arm below low level, count on reaching high level
        if (pins.fast_below) begin
            next_armed = 1'b1;
        end else if (pins.fast_above && armed) begin
            next_armed = 1'b0;
            edge_ev = (in_type == pac_pkg::TYPE_FAST);
        end
        if (in_type == pac_pkg::TYPE_AC) begin
            edge_ev = pins.ac_pos && !ac_prev;
        end
        // Debounce: count accepted closures, swallow short opens
        if (pins.sw_closed != sw_state) begin
            next_sw_cnt = sw_cnt + 15'h1;
            if (!sw_state && sw_cnt == 15'(CLOSE_CYC - 1)) begin
                next_sw_state = 1'b1;
                next_sw_cnt = 15'h0;
                if (in_type == pac_pkg::TYPE_SWITCH) begin
                    edge_ev = 1'b1;
                end
            end else if (sw_state && sw_cnt == 15'(BOUNCE_CYC - 1)) begin
                next_sw_state = 1'b0;
                next_sw_cnt = 15'h0;
            end
        end
        // Clear and count together so a boundary edge lands once
        if (clear) begin
            next_count = {15'h0, edge_ev};
        end else if (edge_ev && count != pac_pkg::CNT_MAX) begin
            next_count = count + 16'h1;
        end else begin
            next_count = count;
        end
    end

    // State registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            armed <= 1'b0;
            ac_prev <= 1'b0;
            sw_state <= 1'b0;
            sw_cnt <= 15'h0;
            count <= 16'h0;
        end else begin
            armed <= next_armed;
            ac_prev <= next_ac_prev;
            sw_state <= next_sw_state;
            sw_cnt <= next_sw_cnt;
            count <= next_count;
        end
    end

endmodule : pac_chan

// File: hw/pac_div.sv
`timescale 1ns/1ps
module pac_div (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Request
    input wire logic start,
    input wire logic [31:0] dividend,
    input wire logic [15:0] divisor,
    // Answer
    output logic [31:0] quotient,
    output logic done
);

    logic busy;
    logic [5:0] step;
    logic [16:0] rem;
    logic next_busy;
    logic [5:0] next_step;
    logic [16:0] next_rem;
    logic [31:0] next_quotient;
    logic next_done;
    logic [16:0] shifted;

    ////////////////////////////////////////////////////////////////////////
    // Restoring division, one quotient bit per cycle
    always_comb begin
        next_busy = busy;
        next_step = step;
        next_rem = rem;
        next_quotient = quotient;
        next_done = 1'b0;
        shifted = {rem[15:0], quotient[31]};
        if (start) begin
            next_busy = 1'b1;
            next_step = 6'h0;
            next_rem = 17'h0;
            next_quotient = dividend;
        end else if (busy) begin
            if (shifted >= {1'b0, divisor}) begin
                next_rem = shifted - {1'b0, divisor};
                next_quotient = {quotient[30:0], 1'b1};
            end else begin
                next_rem = shifted;
                next_quotient = {quotient[30:0], 1'b0};
            end
            next_step = step + 6'h1;
            if (step == 6'(pac_pkg::DIV_STEPS - 1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            step <= 6'h0;
            rem <= 17'h0;
            quotient <= 32'h0;
            done <= 1'b0;
        end else begin
            busy <= next_busy;
            step <= next_step;
            rem <= next_rem;
            quotient <= next_quotient;
            done <= next_done;
        end
    end

endmodule : pac_div

// File: testbench/pac_properties.sv
`timescale 1ns/1ps
module pac_properties (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt
    input wire logic irq
);
    logic acc;
    logic [31:0] cfg_seen;
    logic [31:0] next_cfg_seen;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    ////////////////////
    // Access phase and last written configuration
    assign acc = psel && penable;
    always_comb begin
        next_cfg_seen = cfg_seen;
        if (acc && pwrite && paddr == pac_pkg::OFS_CFG) begin
            next_cfg_seen = pwdata & 32'h3333_3333;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_seen <= 32'h0000_0000;
        end else begin
            cfg_seen <= next_cfg_seen;
        end
    end
    ////////////////////
    // Bus, field and interrupt relations
    ready_in_access_a: assert property (acc |-> pready)
        else $error("pready low in access phase");
    unmapped_error_a: assert property (acc && paddr >= 12'h040
        |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    cfg_readback_a: assert property (
        acc && !pwrite && paddr == 12'h014
        |-> (prdata & 32'h3333_3333) == cfg_seen)
        else $error("configuration readback differs");
    result_range_a: assert property (
        acc && !pwrite && paddr[11:4] == 8'h02
        |-> prdata <= 32'h7fff || prdata == pac_pkg::OVR_HIRES
        || prdata == pac_pkg::OVR_LORES)
        else $error("result outside range");
    count_width_a: assert property (acc && paddr[11:4] == 8'h03
        |-> prdata[31:16] == 16'h0)
        else $error("count wider than 16 bits");
    status_width_a: assert property (acc && paddr == 12'h008
        |-> prdata[31:3] == 29'h0)
        else $error("status has stray bits");
    irq_mask_a: assert property (acc && pwrite && paddr == 12'h010
        && pwdata == 32'h0 |=> !irq [*2])
        else $error("irq stays with all masked");
    irq_after_reset_a: assert property ($rose(resetn) |-> !irq)
        else $error("irq high after reset");
    cover property (acc && pwrite);
    cover property (acc && pslverr);
    cover property ($rose(irq));
endmodule : pac_properties

// File: testbench/pac_sensor.sv
`timescale 1ns/1ps
module pac_sensor (
    // Clock
    input wire logic sys_clk,
    // Command
    input wire logic go,
    input wire logic [2:0] kind,
    input wire logic [7:0] n,
    // Comparator levels
    output pac_pkg::pac_pins_t pins,
    output logic busy
);
    // Hold one level for some cycles
    task automatic level(input logic [3:0] v, input int cyc);
        pins <= v;
        repeat (cyc) @(posedge sys_clk);
    endtask : level
    ////////////////////
    // Trains of n pulses; idle low voltage, switch open
    initial begin
        pins = 4'b0100;
        busy = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (go) begin
                busy <= 1'b1;
                repeat (n) begin
                    case (kind)
                        3'd0: begin
                            level(4'b0100, 40);
                            level(4'b1000, 40);
                        end
                        3'd1: begin
                            level(4'b0110, 40);
                            level(4'b0100, 40);
                        end
                        3'd2: begin
                            level(4'b0101, 12);
                            level(4'b0100, 20);
                        end
                        3'd3: begin
                            level(4'b1000, 40);
                            level(4'b0000, 40);
                        end
                        default: begin
                            level(4'b0101, 12);
                            level(4'b0100, 5);
                            level(4'b0101, 12);
                            level(4'b0100, 20);
                        end
                    endcase
                end
                level(4'b0100, 2);
                busy <= 1'b0;
            end
        end
    end
endmodule : pac_sensor

// File: testbench/pulse_accumulator_interval_bench.sv
`timescale 1ns/1ps
module pulse_accumulator_interval_bench;
    typedef struct {
        logic [7:0] cfg;
        logic [2:0] kind;
        logic [7:0] n;
        logic [15:0] exp;
    } pac_row_t;
    logic sys_clk, resetn, psel, penable, pwrite, seq_hold, go, busy;
    logic pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] kind;
    logic [7:0] n;
    logic [15:0] base [4], sum;
    pac_pkg::pac_pins_t spins;
    pac_pkg::pac_pins_t pins [pac_pkg::NCH];
    int err_total, compares;
    pac_row_t rows [8] = '{'{8'h00, 0, 5, 5}, '{8'h01, 1, 4, 4},
        '{8'h02, 2, 3, 3}, '{8'h00, 3, 5, 1}, '{8'h02, 4, 3, 3},
        '{8'h03, 0, 3, 0}, '{8'h10, 0, 2, 2}, '{8'h21, 1, 2, 2}};
    assign pins = '{spins, spins, spins, spins};
    pac_top #(.MS_CYC(20), .CLOSE_CYC(10), .BOUNCE_CYC(14)) pac_top_inst (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins),
        .seq_hold(seq_hold), .irq(irq));
    pac_sensor pac_sensor_inst (.sys_clk(sys_clk), .go(go), .kind(kind),
        .n(n), .pins(spins), .busy(busy));
    ////////////////////
    // Compare, bus cycle, pulse train, verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected at %0t: %h vs %h", $time, seen, want);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse(input logic [2:0] k, input logic [7:0] c);
        @(posedge sys_clk);
        kind <= k;
        n <= c;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        while (busy === 1'b1) @(posedge sys_clk);
    endtask : pulse
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    // Clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #1000000;
        err_total++;
        complete_run;
    end
    ////////////////////
    // Main sequence
    initial begin
        {resetn, psel, penable, pwrite, seq_hold, go} = 6'h0;
        {paddr, pwdata, kind, n, sum} = '0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        apb(0, pac_pkg::OFS_CFG, 0);
        check(rd, pac_pkg::CFG_RESET);
        apb(0, pac_pkg::OFS_STATUS, 0);
        check(rd, 32'h0);
        foreach (rows[i]) begin
            apb(1, pac_pkg::OFS_CFG, {4{rows[i].cfg}});
            for (int c = 0; c < 4; c++) begin
                apb(0, pac_pkg::OFS_COUNT0 + 12'(4 * c), 0);
                base[c] = rd[15:0];
            end
            pulse(rows[i].kind, rows[i].n);
            for (int c = 0; c < 4; c++) begin
                apb(0, pac_pkg::OFS_COUNT0 + 12'(4 * c), 0);
                rd[15:0] -= base[c];
                check(rd, {16'h0, rows[i].exp});
            end
            sum += rows[i].exp;
            $display("row %0d done", i);
        end
        apb(0, 12'h0fc, 0);
        check({31'h0, er}, 32'h1);
        apb(1, pac_pkg::OFS_ENABLE, 32'h7);
        apb(1, pac_pkg::OFS_CFG, 32'h0);
        seq_hold <= 1'b1;
        apb(1, pac_pkg::OFS_INTERVAL, 32'h2);
        apb(1, pac_pkg::OFS_INTERVAL, 32'h9);
        apb(0, pac_pkg::OFS_INTERVAL, 0);
        check(rd, 32'h2);
        pulse(0, 3);
        seq_hold <= 1'b0;
        repeat (12) @(posedge sys_clk);
        for (int c = 0; c < 4; c++) begin
            apb(0, pac_pkg::OFS_RESULT0 + 12'(4 * c), 0);
            check(rd, {16'h0, sum + 16'h3});
            apb(0, pac_pkg::OFS_COUNT0 + 12'(4 * c), 0);
            check(rd, 32'h0);
        end
        apb(0, pac_pkg::OFS_STATUS, 0);
        check({30'h0, rd[1:0]}, 32'h3);
        $display("long interval done");
        apb(1, pac_pkg::OFS_CFG, 32'h1010_1010);
        repeat (50) @(posedge sys_clk);
        seq_hold <= 1'b1;
        pulse(0, 2);
        seq_hold <= 1'b0;
        repeat (12) @(posedge sys_clk);
        apb(0, pac_pkg::OFS_RESULT0, 0);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h1);
        apb(1, pac_pkg::OFS_ENABLE, 32'h0);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        apb(1, pac_pkg::OFS_CLEAR, 32'h6);
        apb(0, pac_pkg::OFS_STATUS, 0);
        check({30'h0, rd[2:1]}, 32'h0);
        $display("discard and interrupt done");
        complete_run;
    end
endmodule : pulse_accumulator_interval_bench
bind pac_top pac_properties pac_properties_inst (.sys_clk(sys_clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
